// file: hdl/twcp_two_wire_config_port.v
`timescale 1ns/1ns
`include "twcp_defines.vh"
module twcp_two_wire_config_port #(
    parameter POR_CYCLES = `TWCP_POR_CYCLES
) (
    input wire clk,
    input wire rst,
    input wire reset_n,
    input wire addr_strap,
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe,
    input wire [7:0] sync_chsel_status,
    input wire [7:0] sync_act_status,
    output reg standby_r,
    output reg reset_busy_r
);
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_AACK = 3'd2;
    localparam ST_WR = 3'd3;
    localparam ST_WACK = 3'd4;
    localparam ST_RD = 3'd5;
    localparam ST_RACK = 3'd6;
    // ----------------------------------------
    // Synchronisers and SCL deglitch
    // ----------------------------------------
    reg [1:0] scl_s_r, sda_s_r, rstn_s_r, strap_s_r;
    reg [`TWCP_SCL_DELAY-1:0] scl_sh_r;
    reg [`TWCP_SCL_DELAY:0] sda_sh_r;
    reg scl_f_r, sda_d_r;
    always @(posedge clk) begin
        scl_s_r <= {scl_s_r[0], scl_i};
        sda_s_r <= {sda_s_r[0], sda_i};
        rstn_s_r <= {rstn_s_r[0], reset_n};
        strap_s_r <= {strap_s_r[0], addr_strap};
    end
    // Filtered SCL only follows after three equal samples
    always @(posedge clk) begin
        if (rst) begin
            scl_sh_r <= {`TWCP_SCL_DELAY{1'b1}};
            sda_sh_r <= {(`TWCP_SCL_DELAY+1){1'b1}};
            scl_f_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_sh_r <= {scl_sh_r[`TWCP_SCL_DELAY-2:0], scl_s_r[1]};
            // SDA lags as far as filtered SCL, so a data change just after
            // the SCL fall is never mistaken for a start or stop
            sda_sh_r <= {sda_sh_r[`TWCP_SCL_DELAY-1:0], sda_s_r[1]};
            sda_d_r <= sda_sh_r[`TWCP_SCL_DELAY];
            if (&scl_sh_r) begin
                scl_f_r <= 1'b1;
            end else if (~|scl_sh_r) begin
                scl_f_r <= 1'b0;
            end
        end
    end
    reg scl_fd_r;
    always @(posedge clk) begin
        scl_fd_r <= rst ? 1'b1 : scl_f_r;
    end
    wire scl_rise = scl_f_r & ~scl_fd_r;
    wire scl_fall = ~scl_f_r & scl_fd_r;
    wire sda_now = sda_sh_r[`TWCP_SCL_DELAY];
    wire start_det = scl_f_r & sda_d_r & ~sda_now;
    wire stop_det = scl_f_r & ~sda_d_r & sda_now;
    // ----------------------------------------
    // Reset sequencer
    // ----------------------------------------
    // Long count covers power-on and external reset alike
    reg [19:0] por_cnt_r;
    wire full_rst = rst | ~rstn_s_r[1];
    reg init_r;
    reg [7:0] init_addr_r;
    reg addr_lsb_r;
    always @(posedge clk) begin
        if (full_rst) begin
            por_cnt_r <= 20'h0_0000;
            reset_busy_r <= 1'b1;
            init_r <= 1'b1;
            init_addr_r <= 8'h00;
        end else begin
            if (init_r) begin
                init_addr_r <= init_addr_r + 8'h01;
                if (init_addr_r == 8'hff) begin
                    init_r <= 1'b0;
                end
            end
            if (por_cnt_r == POR_CYCLES[19:0] - 20'h0_0001) begin
                reset_busy_r <= 1'b0;
            end else begin
                por_cnt_r <= por_cnt_r + 20'h0_0001;
            end
        end
    end
    // Strap followed while reset_busy_r is high, held once it falls
    always @(posedge clk) begin
        if (reset_busy_r) begin
            addr_lsb_r <= strap_s_r[1];
        end
    end
    // ----------------------------------------
    // Serial state machine
    // ----------------------------------------
    reg [2:0] state_r, state_nxt;
    reg [7:0] shift_r;
    reg [3:0] bit_r;
    reg [7:0] index_r;
    reg idx_loaded_r;
    reg sda_low_r;
    reg mem_we;
    reg [7:0] mem_wdata;
    reg [7:0] mem_waddr;
    wire [7:0] rdata;
    wire addr_hit = (shift_r[7:2] == `TWCP_ADDR_HI) && (shift_r[1] == addr_lsb_r);
    always @(posedge clk) begin
        if (full_rst | reset_busy_r) begin
            state_r <= ST_IDLE;
            shift_r <= 8'h00;
            bit_r <= 4'h0;
            index_r <= 8'h00;
            idx_loaded_r <= 1'b0;
            sda_low_r <= 1'b0;
        end else if (start_det) begin
            state_r <= ST_ADDR;
            bit_r <= 4'h0;
            idx_loaded_r <= 1'b0;
            sda_low_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= ST_IDLE;
            sda_low_r <= 1'b0;
        end else begin
            case (state_r)
                ST_ADDR, ST_WR: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_now};
                        bit_r <= bit_r + 4'h1;
                    end else if (scl_fall && bit_r == 4'h8) begin
                        bit_r <= 4'h0;
                        if (state_r == ST_ADDR) begin
                            if (addr_hit) begin
                                sda_low_r <= 1'b1;
                                state_r <= ST_AACK;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end else begin
                            sda_low_r <= 1'b1;
                            state_r <= ST_WACK;
                            if (idx_loaded_r) begin
                                index_r <= index_r + 8'h01;
                            end else begin
                                index_r <= shift_r;
                                idx_loaded_r <= 1'b1;
                            end
                        end
                    end
                end
                ST_AACK, ST_WACK: begin
                    if (scl_fall) begin
                        if (state_r == ST_AACK && shift_r[0]) begin
                            state_r <= ST_RD;
                            shift_r <= rdata;
                            sda_low_r <= ~rdata[7];
                            bit_r <= 4'h1;
                        end else begin
                            state_r <= ST_WR;
                            sda_low_r <= 1'b0;
                        end
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        if (bit_r == 4'h8) begin
                            sda_low_r <= 1'b0;
                            state_r <= ST_RACK;
                            index_r <= index_r + 8'h01;
                        end else begin
                            sda_low_r <= ~shift_r[3'd7 - bit_r[2:0]];
                            bit_r <= bit_r + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        shift_r[0] <= sda_now;
                    end else if (scl_fall) begin
                        if (shift_r[0]) begin
                            state_r <= ST_IDLE;
                        end else begin
                            state_r <= ST_RD;
                            shift_r <= rdata;
                            sda_low_r <= ~rdata[7];
                            bit_r <= 4'h1;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
    // Sequential read: ack bit sample reuses shift_r[0] after data has been sent
    // ----------------------------------------
    // Register writes, defaults, status
    // ----------------------------------------
    wire host_wr = (state_r == ST_WR) && scl_fall && (bit_r == 4'h8) && idx_loaded_r;
    // Alternate so both status bytes stay fresh whatever the index
    reg stat_sel_r;
    always @(posedge clk) begin
        if (full_rst) begin
            stat_sel_r <= 1'b0;
        end else begin
            stat_sel_r <= ~stat_sel_r;
        end
    end
    always @* begin
        mem_we = 1'b1;
        mem_waddr = index_r;
        mem_wdata = shift_r;
        if (init_r) begin
            mem_waddr = init_addr_r;
            mem_wdata = (init_addr_r == `TWCP_CFG_REG) ? `TWCP_CFG_DEF : `TWCP_RST_DEF;
        end else if (host_wr) begin
            mem_waddr = index_r;
        end else if (!stat_sel_r) begin
            // Status refresh, also in standby
            mem_waddr = `TWCP_STAT_CHSEL;
            mem_wdata = sync_chsel_status;
        end else begin
            mem_waddr = `TWCP_STAT_ACT;
            mem_wdata = sync_act_status;
        end
    end
    always @(posedge clk) begin
        if (full_rst) begin
            standby_r <= 1'b0;
        end else if (host_wr && index_r == `TWCP_STANDBY_REG) begin
            standby_r <= (shift_r == `TWCP_STANDBY_VAL);
        end
    end
    twcp_regmem u_mem (
        .clk(clk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(index_r),
        .rdata(rdata)
    );
    // Port logic ignores standby, so it keeps serving the host
    assign sda_o = 1'b0;
    assign sda_oe = sda_low_r;
endmodule

// file: shared/twcp_defines.vh
`ifndef TWCP_DEFINES_VH
`define TWCP_DEFINES_VH
// ----------------------------------------
// Bus address
// ----------------------------------------
`define TWCP_ADDR_HI 6'h26
// ----------------------------------------
// Register space
// ----------------------------------------
`define TWCP_REG_DEPTH 256
`define TWCP_STANDBY_REG 8'h2c
`define TWCP_STANDBY_VAL 8'h0f
`define TWCP_STAT_CHSEL 8'h01
`define TWCP_STAT_ACT 8'h02
`define TWCP_RST_DEF 8'h00
// Default input config byte at index 0x05 (arbitrary layout)
`define TWCP_CFG_REG 8'h05
`define TWCP_CFG_DEF 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define TWCP_SCL_DELAY 3
`define TWCP_POR_CYCLES 524288
`endif

// file: hdl/twcp_regmem.v
`timescale 1ns/1ns
`include "twcp_defines.vh"
module twcp_regmem (
    input wire clk,
    input wire we,
    input wire [7:0] waddr,
    input wire [7:0] wdata,
    input wire [7:0] raddr,
    output reg [7:0] rdata
);
    reg [7:0] mem [0:`TWCP_REG_DEPTH-1];
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// file: tb/twcp_asserts.sv
`timescale 1ns/1ns
module twcp_asserts #(
    parameter POR_CYCLES = 524288
) (
    input wire clk,
    input wire rst,
    input wire reset_n,
    input wire scl_i,
    input wire sda_o,
    input wire sda_oe,
    input wire standby_r,
    input wire reset_busy_r
);
    int busy_cnt;
    always @(posedge clk) begin
        if (rst || !reset_busy_r)
            busy_cnt <= 0;
        else
            busy_cnt <= busy_cnt + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    busy_quiet_a: assert property (reset_busy_r |-> !sda_oe && !standby_r)
        else $error("bus driven during reset");
    drive_low_a: assert property (sda_oe |-> !sda_o)
        else $error("sda driven high");
    ack_after_fall_a: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i, 3))
        else $error("sda moved too soon after scl");
    hold_on_high_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
        else $error("sda moved while scl high");
    rst_clear_a: assert property ($fell(rst) |-> reset_busy_r && !standby_r)
        else $error("sync reset ignored");
    pin_reset_a: assert property (!reset_n [*6] |-> reset_busy_r)
        else $error("reset pin ignored");
    por_len_a: assert property ($fell(reset_busy_r) |-> busy_cnt >= POR_CYCLES - 2
        && busy_cnt <= POR_CYCLES + 6) else $error("reset count wrong");
    standby_ack_a: assert property ($rose(standby_r) |-> ##[0:16] $rose(sda_oe))
        else $error("standby without ack");
endmodule
bind twcp_two_wire_config_port twcp_asserts #(.POR_CYCLES(POR_CYCLES)) u_twcp_asserts (
    .clk(clk), .rst(rst), .reset_n(reset_n), .scl_i(scl_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .standby_r(standby_r), .reset_busy_r(reset_busy_r));

// file: tb/twcp_host.sv
`timescale 1ns/1ns
module twcp_host (
    output logic scl = 1'b1,
    output logic sda_pull = 1'b0,
    input wire sda
);
    // Low phase kept long: the port's filter needs over five clocks
    localparam int T_HI = 200;
    localparam int T_LO = 320;
    task automatic pulse(input logic b, output logic s);
        #(T_LO / 2) sda_pull = !b;
        #(T_LO / 2) scl = 1'b1;
        #T_HI s = sda;
        scl = 1'b0;
    endtask
    task automatic start();
        #(T_LO / 2) sda_pull = 1'b0;
        #(T_LO / 2) scl = 1'b1;
        #T_HI sda_pull = 1'b1;
        #T_HI scl = 1'b0;
    endtask
    task automatic stop();
        #(T_LO / 2) sda_pull = 1'b1;
        #(T_LO / 2) scl = 1'b1;
        #T_HI sda_pull = 1'b0;
        #T_HI;
    endtask
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) pulse(b[i], s);
        pulse(1'b1, s);
        ack = !s;
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] d, output logic s);
        for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
        pulse(last, s);
    endtask
endmodule

// file: tb/twcp_two_wire_config_port_tb.sv
`timescale 1ns/1ns
`include "twcp_defines.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h want %h", $time, a, e); end end
module twcp_two_wire_config_port_tb;
    logic clk, rst, reset_n, addr_strap, scl, host_pull;
    logic [7:0] chsel, act;
    wire sda_o, sda_oe, standby_r, reset_busy_r;
    wire sda = !(host_pull || (sda_oe && !sda_o));
    int fails = 0;
    int num_checks = 0;
    twcp_two_wire_config_port #(.POR_CYCLES(300)) u_twcp_two_wire_config_port (.clk(clk),
        .rst(rst), .reset_n(reset_n), .addr_strap(addr_strap), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .sync_chsel_status(chsel), .sync_act_status(act),
        .standby_r(standby_r), .reset_busy_r(reset_busy_r));
    twcp_host u_twcp_host (.scl(scl), .sda_pull(host_pull), .sda(sda));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wait_ready();
        for (int n = 0; reset_busy_r !== 1'b0; n++) begin
            if (n == 2000) begin
                fails++;
                conclude();
            end
            @(negedge clk);
        end
    endtask
    task automatic wr(input logic [7:0] dev, input logic [7:0] q[$]);
        logic a;
        u_twcp_host.start();
        u_twcp_host.wr_byte(dev, a);
        `CHK(a, 1'b1)
        foreach (q[i]) begin
            u_twcp_host.wr_byte(q[i], a);
            `CHK(a, 1'b1)
        end
        u_twcp_host.stop();
    endtask
    task automatic rd(input logic [7:0] dev, idx, input logic [7:0] q[$]);
        logic a;
        logic [7:0] d;
        wr(dev, {idx});
        u_twcp_host.start();
        u_twcp_host.wr_byte(dev | 8'h01, a);
        `CHK(a, 1'b1)
        foreach (q[i]) begin
            u_twcp_host.rd_byte(i == q.size() - 1, d, a);
            `CHK(d, q[i])
            `CHK(a, i == q.size() - 1)
        end
        u_twcp_host.stop();
    endtask
    task automatic s_burst();
        `CHK(reset_busy_r, 1'b1)
        wait_ready();
        rd(8'h98, `TWCP_CFG_REG, {`TWCP_CFG_DEF});
        wr(8'h98, {8'hfe, 8'h3c, 8'hc3});
        rd(8'h98, 8'hfe, {8'h3c, 8'hc3});
    endtask
    task automatic s_standby();
        wr(8'h98, {`TWCP_STANDBY_REG, `TWCP_STANDBY_VAL});
        `CHK(standby_r, 1'b1)
        @(negedge clk);
        chsel = 8'h81;
        rd(8'h98, `TWCP_STAT_CHSEL, {8'h81, act});
        wr(8'h98, {`TWCP_STANDBY_REG, 8'h00});
        `CHK(standby_r, 1'b0)
    endtask
    task automatic s_strap();
        logic a;
        @(negedge clk);
        addr_strap = 1'b1;
        reset_n = 1'b0;
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        `CHK(reset_busy_r, 1'b1)
        wait_ready();
        u_twcp_host.start();
        u_twcp_host.wr_byte(8'h98, a);
        `CHK(a, 1'b0)
        u_twcp_host.start();
        u_twcp_host.wr_byte(8'h9a, a);
        `CHK(a, 1'b1)
        u_twcp_host.stop();
        rd(8'h9a, 8'hfe, {8'h00, 8'h00});
    endtask
    initial begin
        rst = 1'b1;
        reset_n = 1'b1;
        addr_strap = 1'b0;
        chsel = 8'h5a;
        act = 8'h3c;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        s_burst();
        s_standby();
        s_strap();
        conclude();
    end
endmodule
